//--- hdl/camera_parallel_pixel_input_port.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "pix_port_defines.svh"
// Operation
// - 10-bit mode keeps only low ten data bits
// - 12-bit mode keeps all twelve data bits
// - 12-bit mode passes syncs raw, unrestricted
// - sampling edge chosen by control bit zero
// - outputs 0,1 mirror remote or local value
// - output 2 mirror/local, or oscillator clock out
// - output 3 mirror/local, or oscillator clock in
// - mode strap picks pixel or oscillator clock
// - power-down stops and restores default registers

// ************************************************************
// fifo with registered output stage
// ************************************************************
module pix_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;  // words held in the array
  logic do_wr;
  logic do_rd;

  // full counts only the array; the output stage is extra slack
  assign in_ready = (count_r != DEPTH[AW:0]);
  assign do_wr = in_valid && in_ready;
  assign do_rd = (count_r != '0) && (!out_valid || out_ready);

  // array write
  always_ff @(posedge aclk) begin
    if (do_wr) begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_r <= count_r + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  // output register so the drain side sees flops only
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (do_rd) begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr_r];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// ************************************************************
// top: pixel capture, general outputs, register slave
// ************************************************************
module camera_parallel_pixel_input_port (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins from the imager
  input wire logic pclk,
  input wire logic [11:0] din,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic power_down_n,
  input wire logic mode_strap,
  // general output pins
  output logic [2:0] general_output,
  output logic general_output3_o,
  output logic general_output3_oe,
  input wire logic general_output3_i,
  // remote gpio states from the deserializer
  input wire logic [3:0] remote_gpio,
  // captured pixel stream
  output logic pix_valid,
  input wire logic pix_ready,
  output pix_port_pkg::pix_word_type pix_word,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ************************************************************
  // declarations
  // ************************************************************
  logic [17:0] pin_s1_r;  // first sync stage, read only by stage two
  logic [17:0] pin_s2_r;  // second sync stage
  logic clk_prev_r;  // delayed capture clock for edge finding
  logic ctrl_edge_r;  // 1: rising edge, 0: falling edge
  logic ctrl_mode_r;  // width mode
  pix_port_pkg::gpo_cfg_type gpo_cfg_r;
  logic osc_mode_r;  // strap caught after release
  logic strap_taken_r;
  logic ls_fault_r;  // sticky sync spacing faults
  logic fs_fault_r;
  logic ovf_r;  // capture lost to a full fifo
  logic [3:0] ls_gap_r;  // captures since last line sync change
  logic [3:0] fs_gap_r;
  logic ls_prev_r;
  logic fs_prev_r;
  logic osc_clk_r;  // divided oscillator clock out
  logic [7:0] osc_cnt_r;
  logic [2:0] gpo_r;
  logic gpo3_r;
  logic gpo3_oe_r;
  logic run;  // synced power-down released
  logic cap_clk;
  logic cap_edge;
  logic fifo_in_ready;
  pix_port_pkg::pix_word_type cap_word;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [7:0] waddr_r;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] status_word;
  logic do_write;
  logic clr_ls;
  logic clr_fs;
  logic clr_ovf;

  // sticky flag: a set in the clearing cycle wins
  function automatic logic sticky_nxt(input logic cur, input logic set, input logic clr);
    sticky_nxt = set || (cur && !clr);
  endfunction

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // every pin from the imager passes two flops before use
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {mode_strap, general_output3_i, power_down_n, pclk, frame_sync, line_sync, din};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign run = pin_s2_r[15];

  // strap is caught once after reset or power-down release
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      strap_taken_r <= 1'b0;
      osc_mode_r <= 1'b0;
    end else if (!strap_taken_r) begin
      strap_taken_r <= 1'b1;
      osc_mode_r <= pin_s2_r[17];
    end
  end

  // ************************************************************
  // capture
  // ************************************************************
  // oscillator mode takes its clock from pin three instead
  assign cap_clk = osc_mode_r ? pin_s2_r[16] : pin_s2_r[14];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_prev_r <= 1'b0;
    end else begin
      clk_prev_r <= cap_clk;
    end
  end

  // edge choice follows the control bit
  assign cap_edge = run && strap_taken_r && (ctrl_edge_r ? (cap_clk && !clk_prev_r)
                                                         : (!cap_clk && clk_prev_r));

  // data and syncs come from the same stage, so they stay aligned
  always_comb begin
    cap_word.line_sync = pin_s2_r[12];
    cap_word.frame_sync = pin_s2_r[13];
    if (ctrl_mode_r == pix_port_pkg::MODE_12) begin
      cap_word.data = pin_s2_r[`PIX_BITS-1:0];
    end else begin
      cap_word.data = {2'h0, pin_s2_r[`LOW_BITS-1:0]};
    end
  end

  pix_fifo #(
    .WIDTH(`WORD_BITS),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(!run),
    .in_valid(cap_edge),
    .in_ready(fifo_in_ready),
    .in_data(cap_word),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data(pix_word)
  );

  // sync spacing watch: in 10-bit mode the imager must not change
  // a sync more than once per ten captures; we only flag it
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ls_gap_r <= `SYNC_GAP;
      fs_gap_r <= `SYNC_GAP;
      ls_prev_r <= 1'b0;
      fs_prev_r <= 1'b0;
    end else if (cap_edge) begin
      ls_prev_r <= cap_word.line_sync;
      fs_prev_r <= cap_word.frame_sync;
      ls_gap_r <= (cap_word.line_sync != ls_prev_r) ? 4'h1
                : (ls_gap_r == `SYNC_GAP) ? ls_gap_r : ls_gap_r + 4'h1;
      fs_gap_r <= (cap_word.frame_sync != fs_prev_r) ? 4'h1
                : (fs_gap_r == `SYNC_GAP) ? fs_gap_r : fs_gap_r + 4'h1;
    end
  end

  // ************************************************************
  // general outputs
  // ************************************************************
  // oscillator clock out is aclk divided down
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || !osc_mode_r) begin
      osc_cnt_r <= '0;
      osc_clk_r <= 1'b0;
    end else if (osc_cnt_r == 8'(`OSC_HALF_CYC - 1)) begin
      osc_cnt_r <= '0;
      osc_clk_r <= !osc_clk_r;
    end else begin
      osc_cnt_r <= osc_cnt_r + 8'h01;
    end
  end

  // each output picks remote mirror or local value; output 2 takes the clock in oscillator mode
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      gpo_r <= '0;
      gpo3_r <= 1'b0;
      gpo3_oe_r <= 1'b0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        gpo_r[i] <= gpo_cfg_r.sel[i] ? gpo_cfg_r.val[i] : remote_gpio[i];
      end
      gpo_r[2] <= osc_mode_r ? osc_clk_r
                : (gpo_cfg_r.sel[2] ? gpo_cfg_r.val[2] : remote_gpio[2]);
      gpo3_r <= gpo_cfg_r.sel[3] ? gpo_cfg_r.val[3] : remote_gpio[3];
      // pin three stays undriven until the strap is known, so an oscillator on it is never fought
      gpo3_oe_r <= strap_taken_r && !osc_mode_r;
    end
  end

  assign general_output = gpo_r;
  assign general_output3_o = gpo3_r;
  assign general_output3_oe = gpo3_oe_r;

  // ************************************************************
  // register write path
  // ************************************************************
  // address and data are held apart and may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      s_axi_awready <= 1'b1;  // ready flags are flops so the bus sees registered outputs
      s_axi_wready <= 1'b1;
      waddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        s_axi_awready <= 1'b0;
        waddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_bresp = `AXI_OKAY;
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;

  // control registers fall back to defaults in power-down
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ctrl_edge_r <= 1'(`CTRL_RESET >> `CTRL_EDGE_BIT);
      ctrl_mode_r <= 1'(`CTRL_RESET >> `CTRL_MODE_BIT);
      gpo_cfg_r <= `GPO_CFG_RESET;
    end else if (do_write && wstrb_r[0]) begin
      if (waddr_r == `ADDR_OF(`IDX_CTRL)) begin
        ctrl_edge_r <= wdata_r[`CTRL_EDGE_BIT];
        ctrl_mode_r <= wdata_r[`CTRL_MODE_BIT];
      end else if (waddr_r == `ADDR_OF(`IDX_GPO_CFG)) begin
        gpo_cfg_r <= wdata_r[7:0];
      end
    end
  end

  // write one to clear the sticky status bits
  assign clr_ls = do_write && wstrb_r[0] && (waddr_r == `ADDR_OF(`IDX_STATUS)) && wdata_r[`ST_LS_BIT];
  assign clr_fs = do_write && wstrb_r[0] && (waddr_r == `ADDR_OF(`IDX_STATUS)) && wdata_r[`ST_FS_BIT];
  assign clr_ovf = do_write && wstrb_r[0] && (waddr_r == `ADDR_OF(`IDX_STATUS)) && wdata_r[`ST_OVF_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      ls_fault_r <= 1'b0;
      fs_fault_r <= 1'b0;
      ovf_r <= 1'b0;
    end else begin
      ls_fault_r <= sticky_nxt(ls_fault_r, cap_edge && ctrl_mode_r == pix_port_pkg::MODE_10 &&
                               cap_word.line_sync != ls_prev_r && ls_gap_r != `SYNC_GAP, clr_ls);
      fs_fault_r <= sticky_nxt(fs_fault_r, cap_edge && ctrl_mode_r == pix_port_pkg::MODE_10 &&
                               cap_word.frame_sync != fs_prev_r && fs_gap_r != `SYNC_GAP, clr_fs);
      ovf_r <= sticky_nxt(ovf_r, cap_edge && !fifo_in_ready, clr_ovf);
    end
  end

  // ************************************************************
  // register read path
  // ************************************************************
  always_comb begin
    status_word = '0;
    status_word[`ST_OSC_BIT] = osc_mode_r;
    status_word[`ST_LS_BIT] = ls_fault_r;
    status_word[`ST_FS_BIT] = fs_fault_r;
    status_word[`ST_OVF_BIT] = ovf_r;
  end

  // one read at a time; unmapped addresses read zero with okay
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr == `ADDR_OF(`IDX_CTRL)) begin
        s_axi_rdata <= {30'h0, ctrl_mode_r, ctrl_edge_r};
      end else if (s_axi_araddr == `ADDR_OF(`IDX_GPO_CFG)) begin
        s_axi_rdata <= {24'h0, gpo_cfg_r};
      end else if (s_axi_araddr == `ADDR_OF(`IDX_STATUS)) begin
        s_axi_rdata <= status_word;
      end else begin
        s_axi_rdata <= '0;
      end
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  assign s_axi_rresp = `AXI_OKAY;
endmodule

//--- hdl/pix_port_defines.svh
`ifndef PIX_PORT_DEFINES_SVH
`define PIX_PORT_DEFINES_SVH
// ************************************************************
// register indices and byte addresses
// ************************************************************
`define IDX_CTRL 8'h03
`define IDX_GPO_CFG 8'h0D
`define IDX_STATUS 8'h0E
`define ADDR_OF(idx) (8'({(idx), 2'b00}))
// ************************************************************
// control fields and reset values
// ************************************************************
`define CTRL_EDGE_BIT 0
`define CTRL_MODE_BIT 1
`define CTRL_RESET 2'h1
`define GPO_CFG_RESET 8'h00
// gpo config: source select in [3:0], local value in [7:4]
`define GPO_SEL_LSB 0
`define GPO_VAL_LSB 4
// status: [0] osc mode, [1] line sync fault, [2] frame sync fault, [3] overflow
`define ST_OSC_BIT 0
`define ST_LS_BIT 1
`define ST_FS_BIT 2
`define ST_OVF_BIT 3
// ************************************************************
// widths and timing
// ************************************************************
`define PIX_BITS 12
`define LOW_BITS 10
`define WORD_BITS 14
`define FIFO_DEPTH 16
`define SYNC_GAP 4'hA
`define OSC_HALF_NS 20
`define CLK_NS 10
`define OSC_HALF_CYC (`OSC_HALF_NS / `CLK_NS)
`define AXI_OKAY 2'h0
`endif

//--- hdl/pix_port_pkg.sv
package pix_port_pkg;
  // one captured pixel with its syncs kept beside it
  typedef struct packed {
    logic frame_sync;
    logic line_sync;
    logic [11:0] data;
  } pix_word_type;
  // capture width mode
  typedef enum logic {
    MODE_10 = 1'b0,
    MODE_12 = 1'b1
  } width_mode_type;
  // general output config
  typedef struct packed {
    logic [3:0] val;
    logic [3:0] sel;
  } gpo_cfg_type;
endpackage

//--- testbench/camera_parallel_pixel_input_port_bench.sv
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin n_errors++; $display("mismatch %0t %s", $time, msg); end end
// ********
// bench: sensor model, register master, pixel sink
// ********
module camera_parallel_pixel_input_port_bench;
  logic aclk, aresetn, power_down_n, mode_strap, pix_ready, go, fall, stall, m12, o2;
  logic pclk, line_sync, frame_sync, pix_valid, general_output3_o, general_output3_oe;
  logic awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic [3:0] gap, remote_gpio;
  logic [2:0] general_output;
  logic [11:0] din;
  logic [7:0] awaddr, araddr, gcfg;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp;
  pix_port_pkg::pix_word_type pix_word, expw;
  pix_port_pkg::pix_word_type q[$]; // words the sensor presented
  int n_errors, n_checks, lim, cyc;
  camera_parallel_pixel_input_port dut_u (
    .aclk(aclk), .aresetn(aresetn), .pclk(pclk), .din(din), .line_sync(line_sync), .frame_sync(frame_sync),
    .power_down_n(power_down_n), .mode_strap(mode_strap), .general_output(general_output),
    .general_output3_o(general_output3_o), .general_output3_oe(general_output3_oe),
    .general_output3_i(general_output3_oe ? general_output3_o : pclk), .remote_gpio(remote_gpio),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_word(pix_word),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1)
  );
  pix_sensor_model snd_u (
    .go(go), .fall_edge(fall), .gap(gap), .pclk(pclk), .din(din), .line_sync(line_sync), .frame_sync(frame_sync)
  );
  // expected captured word: narrow mode drops the two upper bits
  function automatic pix_port_pkg::pix_word_type exp_word(input logic [11:0] d, input logic ls, input logic fs);
    exp_word = {fs, ls, m12 ? d : {2'h0, d[9:0]}};
  endfunction
  // expected pin levels: select 1 takes the local value
  function automatic logic [3:0] gpo_exp(input logic [7:0] c, input logic [3:0] r);
    gpo_exp = (c[3:0] & c[7:4]) | (~c[3:0] & r);
  endfunction
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // record each word at the sampling edge; lim models the buffer limit when stalled
  always @(pclk) begin
    if (pclk == !fall && q.size() < lim) q.push_back(exp_word(din, line_sync, frame_sync));
  end
  // sink with random stalls
  always @(posedge aclk) begin
    pix_ready <= !stall && ($urandom_range(3) != 0);
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      expw = q.pop_front();
      `CHK(pix_word, expw, "pixel word")
    end
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_errors++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    `CHK(bresp, 2'h0, "write response")
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a, rd);
    `CHK(rd & m, e, "register read")
  endtask
  task automatic do_reset(input logic strap);
    aresetn <= 1'b0;
    mode_strap <= strap;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  task automatic frame(input logic [3:0] g, input int l);
    gap <= g;
    lim = l;
    go <= 1'b1;
    wait (snd_u.n == 40);
    go <= 1'b0;
    @(posedge aclk);
  endtask
  // let the last sampled words arrive, then wait for the sink to empty
  task automatic drain;
    repeat (20) @(posedge aclk);
    while (q.size() != 0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask
  initial begin
    {aresetn, mode_strap, pix_ready, go, fall, stall, m12, awvalid, wvalid, arvalid} = 10'h000;
    {power_down_n, gap, remote_gpio, awaddr, araddr, wdata, gcfg} = 65'h0;
    power_down_n = 1'b1;
    n_errors = 0;
    n_checks = 0;
    lim = 0;
    cyc = 0;
    void'($urandom(7));
    do_reset(1'b0);
    rchk(8'h0C, 32'h3, 32'h1);
    rchk(8'h34, 32'hFF, 32'h0);
    rchk(8'h20, 32'hFFFFFFFF, 32'h0);
    // every width mode and edge, legal sync spacing first, then too-close syncs
    for (int i = 0; i < 8; i++) begin
      m12 = i[0];
      fall <= !i[1];
      axw(8'h0C, {30'h0, i[0], i[1]});
      frame(i[2] ? 4'h3 : 4'hA, 1000);
      drain;
      rchk(8'h38, 32'h6, (i[2] && !i[0]) ? 32'h6 : 32'h0);
      axw(8'h38, 32'hE);
      rchk(8'h38, 32'hE, 32'h0);
    end
    // sink stalled: buffer plus output stage hold 17 words, the rest are dropped
    stall = 1'b1;
    frame(4'hA, 17);
    rchk(8'h38, 32'h8, 32'h8);
    stall = 1'b0;
    drain;
    for (int i = 0; i < 8; i++) begin
      gcfg = 8'($urandom);
      remote_gpio <= 4'($urandom);
      axw(8'h34, {24'h0, gcfg});
      repeat (3) @(posedge aclk);
      `CHK({general_output3_o, general_output}, gpo_exp(gcfg, remote_gpio), "general outputs")
      `CHK(general_output3_oe, 1'b1, "pin 3 drive")
    end
    axw(8'h0C, 32'h2);
    power_down_n <= 1'b0;
    repeat (6) @(posedge aclk);
    `CHK({general_output3_oe, general_output}, 4'h0, "power down outputs")
    power_down_n <= 1'b1;
    repeat (8) @(posedge aclk);
    rchk(8'h0C, 32'h3, 32'h1);
    rchk(8'h34, 32'hFF, 32'h0);
    // oscillator mode: pin 3 becomes the capture clock, output 2 a clock
    m12 = 1'b0;
    fall <= 1'b0;
    do_reset(1'b1);
    rchk(8'h38, 32'h1, 32'h1);
    o2 = general_output[2];
    repeat (2) @(posedge aclk);
    `CHK(general_output[2], !o2, "oscillator clock out")
    `CHK(general_output3_oe, 1'b0, "pin 3 as input")
    frame(4'hA, 1000);
    drain;
    print_verdict;
  end
endmodule

//--- testbench/pix_port_chk.sv
`timescale 1ns/1ps
// ********
// checker on the top ports
// ********
module pix_port_chk (
  // clock, reset, straps
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic power_down_n,
  input wire logic mode_strap,
  // general outputs
  input wire logic [3:0] remote_gpio,
  input wire logic [2:0] general_output,
  input wire logic general_output3_o,
  input wire logic general_output3_oe,
  // pixel stream
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire pix_port_pkg::pix_word_type pix_word,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp
);
  logic mode_r; // shadow of the width mode bit
  logic [7:0] cfg_r; // shadow of the output config
  logic [3:0] rg_r; // remote states one cycle back
  logic [2:0] quiet_r; // cycles since a config, remote or power change
  logic wr_w;
  logic [3:0] mux_w; // expected pin levels
  assign wr_w = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign mux_w = (cfg_r[3:0] & cfg_r[7:4]) | (~cfg_r[3:0] & rg_r);
  // shadows follow bus writes; power-down drops them to defaults
  always_ff @(posedge aclk) begin
    if (!aresetn || !power_down_n) begin
      mode_r <= 1'b0;
      cfg_r <= 8'h00;
    end else if (wr_w && s_axi_awaddr == 8'h0C) begin
      mode_r <= s_axi_wdata[1];
    end else if (wr_w && s_axi_awaddr == 8'h34) begin
      cfg_r <= s_axi_wdata[7:0];
    end
  end
  // outputs are registered, so they are judged only once the inputs are calm
  always_ff @(posedge aclk) begin
    rg_r <= remote_gpio;
    if (!aresetn || !power_down_n || wr_w || remote_gpio != rg_r) begin
      quiet_r <= 3'h0;
    end else if (quiet_r != 3'h7) begin
      quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    wr_w;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_wr_resp;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  property p_rd_resp;
    s_rd_taken |=> s_axi_rvalid && s_axi_rresp == 2'h0;
  endproperty
  property p_low_bits;
    pix_valid && !mode_r |-> pix_word.data[11:10] == 2'h0;
  endproperty
  property p_hold_word;
    pix_valid && !pix_ready && power_down_n |=> pix_valid && $stable(pix_word);
  endproperty
  property p_pd_quiet;
    !power_down_n [*4] |-> general_output == 3'h0 && !general_output3_oe && !pix_valid;
  endproperty
  property p_gpo_low;
    quiet_r >= 3'h5 && remote_gpio == rg_r |-> general_output[1:0] == mux_w[1:0];
  endproperty
  property p_gpo_high;
    quiet_r >= 3'h5 && remote_gpio == rg_r && general_output3_oe |->
      general_output[2] == mux_w[2] && general_output3_o == mux_w[3];
  endproperty
  property p_pin3_dir;
    power_down_n [*8] |-> general_output3_oe == !mode_strap;
  endproperty
  property p_osc_clk;
    (mode_strap && power_down_n && !general_output3_oe) [*8] |-> general_output[2] != $past(general_output[2], 2);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
  a_rd_resp: assert property (p_rd_resp) else $error("read response missing");
  a_low_bits: assert property (p_low_bits) else $error("upper bits kept in narrow mode");
  a_hold_word: assert property (p_hold_word) else $error("pixel word moved while stalled");
  a_pd_quiet: assert property (p_pd_quiet) else $error("outputs active in power-down");
  a_gpo_low: assert property (p_gpo_low) else $error("outputs 0 or 1 wrong source");
  a_gpo_high: assert property (p_gpo_high) else $error("outputs 2 or 3 wrong source");
  a_pin3_dir: assert property (p_pin3_dir) else $error("pin 3 direction wrong");
  a_osc_clk: assert property (p_osc_clk) else $error("oscillator clock not toggling");
endmodule
bind camera_parallel_pixel_input_port pix_port_chk chk_u (
  .aclk(aclk), .aresetn(aresetn), .power_down_n(power_down_n), .mode_strap(mode_strap),
  .remote_gpio(remote_gpio), .general_output(general_output), .general_output3_o(general_output3_o),
  .general_output3_oe(general_output3_oe), .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_word(pix_word),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp)
);

//--- testbench/pix_sensor_model.sv
`timescale 1ns/1ps
// ********
// image sensor: pixel clock, data and syncs
// ********
module pix_sensor_model (
  // frame control
  input wire logic go,
  input wire logic fall_edge,
  input wire logic [3:0] gap,
  // sensor pins
  output logic pclk,
  output logic [11:0] din,
  output logic line_sync,
  output logic frame_sync
);
  int n; // words launched in this frame
  // launch on the edge opposite the sampling edge so data is settled when sampled
  initial begin
    pclk = 1'b0;
    din = 12'h000;
    line_sync = 1'b0;
    frame_sync = 1'b0;
    n = 0;
    #2; // keep pin edges off the system clock edges
    forever begin
      #62.5;
      if ((go && n < 40) || pclk) begin
        pclk = ~pclk;
        if (pclk == fall_edge && n < 40) begin
          din = 12'($urandom);
          n++;
          if (n % gap == 0) line_sync = ~line_sync;
          if (n % gap == gap / 2) frame_sync = ~frame_sync;
        end
      end else begin
        // clock stands still between frames; pull-downs take the lines low
        din = 12'h000;
        line_sync = 1'b0;
        frame_sync = 1'b0;
        if (!go) n = 0;
      end
    end
  end
endmodule
